// file: verilog/seefe_top.sv
// Overview of operation
// - capture every input bit on a rising shift-clock edge, both modes.
// - drive each output bit on a falling shift-clock edge.
// - chip select high tri-states output and enters standby unless writing.
// - write-protect low inhibits every write operation.
// - while paused, freeze all serial state and resume exactly there.
// - internal write cycle lasts 5 ms, counted from the synchronised chip-select rise.
// - accept only the six opcodes; ignore all other bytes.
// - during internal write, ignore everything except status read.
// - busy bit is 1 throughout internal write, 0 afterwards.
module seefe_top import seefe_pkg::*; #(
    parameter int unsigned WRITE_CYCLES = SEEFE_WRITE_CYC
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire seefe_pins_t pins_i,
    output logic             so_o,
    output logic             so_oe_o,
    output logic             busy_o,
    output logic             write_latch_o,
    output logic             standby_o
);

    seefe_pins_t           s1_q;
    seefe_pins_t           s2_q;
    seefe_pins_t           p_q;
    seefe_state_t          state_q;
    logic [2:0]            bitcnt_q;
    logic [6:0]            sr_q;
    logic                  rd_q;
    logic                  latch_val_q;
    logic [8:0]            addr_q;
    logic [7:0]            buf_q [SEEFE_PAGE_BYTES];
    logic [15:0]           mask_q;
    logic                  have_q;
    logic [1:0]            bp_q;
    logic [1:0]            bp_new_q;
    logic                  write_latch_q;
    logic                  busy_q;
    logic                  commit_sr_q;
    logic [SEEFE_CYC_W-1:0] cyc_q;
    logic [2:0]            obit_q;
    logic [7:0]            obyte_q;
    logic [7:0]            mem_rdata;
    logic                  active;
    logic                  rise;
    logic                  fall;
    logic                  done8;
    logic                  cs_rise;
    logic                  wr_abort;
    logic                  start;
    logic                  cyc_end;
    logic                  mem_we;
    logic [7:0]            byte_in;
    logic [7:0]            status;
    logic [7:0]            out_src;
    seefe_cmd_t            cmd;

    // pin synchronisers and edge history
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, wp_n: 1'b0, hold_n: 1'b1};
            s2_q <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, wp_n: 1'b0, hold_n: 1'b1};
            p_q  <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, wp_n: 1'b0, hold_n: 1'b1};
        end else begin
            s1_q <= pins_i;
            s2_q <= s1_q;
            p_q  <= s2_q;
        end
    end

    assign active   = !s2_q.cs_n && s2_q.hold_n;
    assign rise     = active && s2_q.sck && !p_q.sck;
    assign fall     = active && !s2_q.sck && p_q.sck;
    assign done8    = rise && (bitcnt_q == 3'h7);
    assign byte_in  = {sr_q, s2_q.si};
    assign cmd      = seefe_decode(byte_in);
    assign cs_rise  = s2_q.cs_n && !p_q.cs_n;
    assign cyc_end  = busy_q && (cyc_q == SEEFE_CYC_W'(WRITE_CYCLES - 1));
    assign status   = {SEEFE_SR_TOP, bp_q, write_latch_q, busy_q};
    assign out_src  = (state_q == ST_SROUT) ? status : mem_rdata;
    assign wr_abort = !s2_q.wp_n && ((state_q == ST_WDATA) || (state_q == ST_SRIN)
                      || ((state_q == ST_ADDR) && !rd_q));
    assign start    = cs_rise && (bitcnt_q == 3'h0) && s2_q.wp_n && have_q
                      && ((state_q == ST_WDATA) || (state_q == ST_SRIN));
    assign mem_we   = busy_q && !commit_sr_q && (cyc_q < SEEFE_CYC_W'(SEEFE_PAGE_BYTES))
                      && mask_q[cyc_q[3:0]];

    // instruction sequencing
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_OPC;
        end else if (s2_q.cs_n) begin
            state_q <= ST_OPC;
        end else if (wr_abort) begin
            state_q <= ST_IGN;
        end else if (done8) begin
            case (state_q)
                ST_OPC: begin
                    if (busy_q && cmd != CMD_STATUS_RD) begin
                        state_q <= ST_IGN;
                    end else begin
                        case (cmd)
                            CMD_SET_LATCH, CMD_CLEAR_LATCH: state_q <= ST_LATCH;
                            CMD_STATUS_RD: state_q <= ST_SROUT;
                            CMD_STATUS_WR: state_q <= (write_latch_q && s2_q.wp_n) ? ST_SRIN : ST_IGN;
                            CMD_READ:      state_q <= ST_ADDR;
                            CMD_WRITE:     state_q <= (write_latch_q && s2_q.wp_n) ? ST_ADDR : ST_IGN;
                            default:       state_q <= ST_IGN;
                        endcase
                    end
                end
                ST_ADDR: begin
                    if (rd_q) begin
                        state_q <= ST_RDATA;
                    end else if (seefe_protected(bp_q, {addr_q[8], byte_in})) begin
                        state_q <= ST_IGN;
                    end else begin
                        state_q <= ST_WDATA;
                    end
                end
                ST_LATCH: state_q <= ST_IGN;
                default:  state_q <= state_q;
            endcase
        end
    end

    // bit shifting, address and page buffer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bitcnt_q    <= 3'h0;
            sr_q        <= 7'h00;
            rd_q        <= 1'b0;
            latch_val_q <= 1'b0;
            addr_q      <= 9'h000;
            mask_q      <= 16'h0000;
            have_q      <= 1'b0;
            bp_new_q    <= SEEFE_BP_RESET;
        end else if (s2_q.cs_n) begin
            bitcnt_q <= 3'h0;
        end else if (rise) begin
            bitcnt_q <= bitcnt_q + 3'h1;
            sr_q     <= byte_in[6:0];
            if (done8) begin
                case (state_q)
                    ST_OPC: begin
                        if (!busy_q) begin
                            rd_q        <= (cmd == CMD_READ);
                            latch_val_q <= (cmd == CMD_SET_LATCH);
                            addr_q[8]   <= byte_in[SEEFE_OP_HIADDR_BIT];
                            mask_q      <= 16'h0000;
                            have_q      <= 1'b0;
                        end
                    end
                    ST_ADDR:  addr_q[7:0] <= byte_in;
                    ST_WDATA: begin
                        mask_q[addr_q[3:0]] <= 1'b1;
                        addr_q[3:0]         <= addr_q[3:0] + 4'h1;
                        have_q              <= 1'b1;
                    end
                    ST_SRIN: begin
                        bp_new_q <= byte_in[SEEFE_SR_BP_LSB +: 2];
                        have_q   <= 1'b1;
                    end
                    default: have_q <= have_q;
                endcase
            end
        end else if (fall && state_q == ST_RDATA && obit_q == 3'h7) begin
            addr_q <= addr_q + 9'h001;
        end
    end

    always_ff @(posedge clk) begin
        if (done8 && state_q == ST_WDATA) begin
            buf_q[addr_q[3:0]] <= byte_in;
        end
    end

    // self-timed write cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_q      <= 1'b0;
            cyc_q       <= '0;
            commit_sr_q <= 1'b0;
        end else if (start) begin
            busy_q      <= 1'b1;
            cyc_q       <= '0;
            commit_sr_q <= (state_q == ST_SRIN);
        end else if (busy_q) begin
            cyc_q <= cyc_q + SEEFE_CYC_W'(1);
            if (cyc_end) begin
                busy_q <= 1'b0;
            end
        end
    end

    // write latch and block protection
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            write_latch_q <= 1'b0;
            bp_q          <= SEEFE_BP_RESET;
        end else begin
            if (cs_rise && state_q == ST_LATCH && bitcnt_q == 3'h0) begin
                write_latch_q <= latch_val_q;
            end else if (cyc_end) begin
                write_latch_q <= 1'b0;
            end
            if (busy_q && commit_sr_q && cyc_q == '0) begin
                bp_q <= bp_new_q;
            end
        end
    end

    // serial output
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            so_o    <= 1'b0;
            so_oe_o <= 1'b0;
            obit_q  <= 3'h7;
            obyte_q <= 8'h00;
        end else begin
            so_oe_o <= active && (state_q == ST_SROUT || state_q == ST_RDATA);
            if (s2_q.cs_n) begin
                obit_q <= 3'h7;
            end else if (fall && (state_q == ST_SROUT || state_q == ST_RDATA)) begin
                obit_q <= obit_q - 3'h1;
                if (obit_q == 3'h7) begin
                    obyte_q <= out_src;
                    so_o    <= out_src[7];
                end else begin
                    so_o <= obyte_q[obit_q];
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_o        <= 1'b0;
            write_latch_o <= 1'b0;
            standby_o     <= 1'b1;
        end else begin
            busy_o        <= busy_q;
            write_latch_o <= write_latch_q;
            standby_o     <= s2_q.cs_n && !busy_q;
        end
    end

    seefe_mem u_mem (
        .clk     (clk),
        .we      (mem_we),
        .waddr   ({addr_q[8:4], cyc_q[3:0]}),
        .wdata   (buf_q[cyc_q[3:0]]),
        .raddr   (addr_q),
        .rdata_q (mem_rdata)
    );

endmodule

// file: common/seefe_pkg.sv
package seefe_pkg;

    localparam int unsigned SEEFE_CLK_MHZ      = 125;
    localparam int unsigned SEEFE_T_WRITE_MS   = 5;
    localparam int unsigned SEEFE_WRITE_CYC    = SEEFE_T_WRITE_MS * SEEFE_CLK_MHZ * 1000;
    localparam int unsigned SEEFE_T_POWERUP_MS = 1;
    localparam int unsigned SEEFE_CYC_W        = 20;
    localparam int unsigned SEEFE_ADDR_W       = 9;
    localparam int unsigned SEEFE_MEM_DEPTH    = 512;
    localparam int unsigned SEEFE_PAGE_BYTES   = 16;

    localparam logic [7:0] SEEFE_OP_SET_LATCH   = 8'h06;
    localparam logic [7:0] SEEFE_OP_CLEAR_LATCH = 8'h04;
    localparam logic [7:0] SEEFE_OP_STATUS_RD   = 8'h05;
    localparam logic [7:0] SEEFE_OP_STATUS_WR   = 8'h01;
    localparam logic [2:0] SEEFE_OP_READ_LO     = 3'h3;
    localparam logic [2:0] SEEFE_OP_WRITE_LO    = 3'h2;
    localparam int unsigned SEEFE_OP_HIADDR_BIT = 3;

    localparam logic [3:0] SEEFE_SR_TOP       = 4'hF;
    localparam int unsigned SEEFE_SR_BP_LSB   = 2;
    localparam logic [1:0] SEEFE_BP_RESET     = 2'h0;
    localparam logic [8:0] SEEFE_QUARTER_BASE = 9'h180;
    localparam logic [8:0] SEEFE_HALF_BASE    = 9'h100;

    typedef struct packed {
        logic cs_n;
        logic sck;
        logic si;
        logic wp_n;
        logic hold_n;
    } seefe_pins_t;

    typedef enum logic [7:0] {
        ST_OPC   = 8'h01,
        ST_ADDR  = 8'h02,
        ST_WDATA = 8'h04,
        ST_RDATA = 8'h08,
        ST_SROUT = 8'h10,
        ST_SRIN  = 8'h20,
        ST_LATCH = 8'h40,
        ST_IGN   = 8'h80
    } seefe_state_t;

    typedef enum logic [2:0] {
        CMD_NONE, CMD_SET_LATCH, CMD_CLEAR_LATCH, CMD_STATUS_RD, CMD_STATUS_WR, CMD_READ, CMD_WRITE
    } seefe_cmd_t;

    function automatic seefe_cmd_t seefe_decode(input logic [7:0] op);
        seefe_cmd_t c;
        c = CMD_NONE;
        if (op == SEEFE_OP_SET_LATCH) c = CMD_SET_LATCH;
        else if (op == SEEFE_OP_CLEAR_LATCH) c = CMD_CLEAR_LATCH;
        else if (op == SEEFE_OP_STATUS_RD) c = CMD_STATUS_RD;
        else if (op == SEEFE_OP_STATUS_WR) c = CMD_STATUS_WR;
        else if (op[7:4] == 4'h0 && op[2:0] == SEEFE_OP_READ_LO) c = CMD_READ;
        else if (op[7:4] == 4'h0 && op[2:0] == SEEFE_OP_WRITE_LO) c = CMD_WRITE;
        return c;
    endfunction

    function automatic logic seefe_protected(input logic [1:0] bp, input logic [8:0] addr);
        logic p;
        p = 1'b0;
        case (bp)
            2'h1:    p = (addr >= SEEFE_QUARTER_BASE);
            2'h2:    p = (addr >= SEEFE_HALF_BASE);
            2'h3:    p = 1'b1;
            default: p = 1'b0;
        endcase
        return p;
    endfunction

endpackage

// file: verilog/seefe_mem.sv
module seefe_mem import seefe_pkg::*; (
    input  wire logic                    clk,
    input  wire logic                    we,
    input  wire logic [SEEFE_ADDR_W-1:0] waddr,
    input  wire logic [7:0]              wdata,
    input  wire logic [SEEFE_ADDR_W-1:0] raddr,
    output logic      [7:0]              rdata_q
);

    logic [7:0] mem [SEEFE_MEM_DEPTH];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        rdata_q <= mem[raddr];
    end

endmodule

// file: tb/seefe_top_props.sv
module seefe_top_props import seefe_pkg::*; #(
    parameter int unsigned WRITE_CYCLES = SEEFE_WRITE_CYC
) (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire seefe_pins_t pins_i,
    input wire logic        so_o,
    input wire logic        so_oe_o,
    input wire logic        busy_o,
    input wire logic        write_latch_o,
    input wire logic        standby_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [SEEFE_CYC_W-1:0] cnt_q;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // busy length counter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) cnt_q <= '0;
        else if (busy_o) cnt_q <= cnt_q + SEEFE_CYC_W'(1);
        else cnt_q <= '0;
    end
    property p_stby_busy;
        busy_o && $past(busy_o) |-> !standby_o;
    endproperty
    a_stby_busy: assert property (p_stby_busy) else $error("standby while busy");
    property p_stby_cs;
        !pins_i.cs_n [*5] |-> !standby_o;
    endproperty
    a_stby_cs: assert property (p_stby_cs) else $error("standby while selected");
    property p_oe_cs;
        pins_i.cs_n [*5] |-> !so_oe_o;
    endproperty
    a_oe_cs: assert property (p_oe_cs) else $error("output driven while deselected");
    property p_oe_sess;
        $rose(so_oe_o) |-> !pins_i.cs_n && !$past(pins_i.cs_n, 4);
    endproperty
    a_oe_sess: assert property (p_oe_sess) else $error("output enabled outside session");
    property p_so_edge;
        $changed(so_o) && so_oe_o |-> !pins_i.sck;
    endproperty
    a_so_edge: assert property (p_so_edge) else $error("output moved with clock high");
    property p_busy_len;
        $fell(busy_o) |-> cnt_q == SEEFE_CYC_W'(WRITE_CYCLES);
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("write cycle length wrong");
    property p_latch_clr;
        $fell(busy_o) |-> ##[0:2] !write_latch_o;
    endproperty
    a_latch_clr: assert property (p_latch_clr) else $error("latch kept after write");
    property p_wp;
        $rose(busy_o) |-> $past(pins_i.wp_n, 8);
    endproperty
    a_wp: assert property (p_wp) else $error("write started while protected");
    property p_hold;
        !pins_i.hold_n [*5] |-> !so_oe_o;
    endproperty
    a_hold: assert property (p_hold) else $error("output driven while paused");
endmodule

bind seefe_top seefe_top_props #(.WRITE_CYCLES(WRITE_CYCLES)) u_props (
    .clk(clk), .rst_n(rst_n), .pins_i(pins_i), .so_o(so_o), .so_oe_o(so_oe_o),
    .busy_o(busy_o), .write_latch_o(write_latch_o), .standby_o(standby_o)
);

// file: tb/seefe_host.sv
module seefe_host import seefe_pkg::*; (
    input  wire logic   clk,
    output seefe_pins_t pins,
    input  wire logic   so
);
    timeunit 1ns;
    timeprecision 100ps;
    logic mode3 = 1'b0;
    initial pins = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, wp_n: 1'b1, hold_n: 1'b1};
    // idle clock level: low for mode 0, high for mode 3
    task automatic set_mode3(input logic m);
        mode3 = m;
    endtask
    task automatic set_wp(input logic v);
        pins.wp_n = v;
    endtask
    // start off the system clock grid so no pin moves on a sampling edge
    task automatic cs_lo();
        @(posedge clk);
        #1.2 pins.sck = mode3;
        #40 pins.cs_n = 1'b0;
        #40;
    endtask
    task automatic cs_hi();
        #40 pins.cs_n = 1'b1;
        pins.si = ~pins.si;
        #100;
    endtask
    // one byte msb first, optional pause before bit ph
    task automatic xb(input logic [7:0] tx, input int ph, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            if (mode3) begin
                #62.5 pins.sck = 1'b0;
            end
            if (i == ph) begin
                #20 pins.hold_n = 1'b0;
                #200 pins.hold_n = 1'b1;
                #40;
            end
            pins.si = tx[i];
            #62.5 pins.sck = 1'b1;
            rx[i] = so;
            if (!mode3) begin
                #62.5 pins.sck = 1'b0;
            end
        end
    endtask
endmodule

// file: tb/tb.sv
module tb import seefe_pkg::*; ();
    timeunit 1ns;
    timeprecision 100ps;
    localparam int unsigned WC = 800;
    logic        clk;
    logic        rst_n;
    seefe_pins_t pins;
    logic        so_o;
    logic        so_oe_o;
    logic        busy_o;
    logic        write_latch_o;
    logic        standby_o;
    wire logic   so_w;
    int          num_errors = 0;
    int          checks_done = 0;
    assign so_w = so_oe_o ? so_o : 1'bz;
    seefe_top #(.WRITE_CYCLES(WC)) u_dut (
        .clk(clk), .rst_n(rst_n), .pins_i(pins), .so_o(so_o), .so_oe_o(so_oe_o),
        .busy_o(busy_o), .write_latch_o(write_latch_o), .standby_o(standby_o)
    );
    seefe_host u_host (.clk(clk), .pins(pins), .so(so_w));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic final_report();
        $display("mismatches %0d of %0d checks", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] fl();
        return {4'h0, so_oe_o, busy_o, write_latch_o, standby_o};
    endfunction
    task automatic sess(input logic [7:0] a, input logic [7:0] b, input int n, output logic [7:0] rx);
        u_host.cs_lo();
        u_host.xb(a, -1, rx);
        if (n > 1) u_host.xb(b, -1, rx);
        u_host.cs_hi();
    endtask
    task automatic wr(input logic [7:0] d);
        logic [7:0] r;
        u_host.cs_lo();
        u_host.xb(8'h02, -1, r);
        u_host.xb(8'h10, -1, r);
        u_host.xb(d, -1, r);
        u_host.cs_hi();
    endtask
    task automatic wait_busy(input logic lvl, input int n);
        for (int i = 0; i < n && busy_o !== lvl; i++) @(posedge clk);
    endtask
    task automatic t_latch();
        logic [7:0] r;
        sess(8'hFF, 8'h06, 2, r);
        chk(fl(), 8'h01);
        sess(8'h06, 8'h00, 2, r);
        chk(fl(), 8'h01);
        sess(8'h06, 8'h00, 1, r);
        chk(fl(), 8'h03);
        sess(8'h04, 8'h00, 1, r);
        chk(fl(), 8'h01);
        $display("test latch done");
    endtask
    task automatic t_write();
        logic [7:0] r;
        sess(8'h06, 8'h00, 1, r);
        u_host.set_wp(1'b0);
        wr(8'h5A);
        wait_busy(1'b1, 40);
        chk({7'h00, busy_o}, 8'h00);
        u_host.set_wp(1'b1);
        wr(8'hA5);
        wait_busy(1'b1, 20);
        chk(fl(), 8'h06);
        sess(8'h05, 8'h00, 2, r);
        chk(r, 8'hF3);
        sess(8'h04, 8'h00, 1, r);
        chk({7'h00, write_latch_o}, 8'h01);
        wait_busy(1'b0, WC);
        repeat (3) @(posedge clk);
        #1 chk(fl(), 8'h01);
        sess(8'h05, 8'h00, 2, r);
        chk(r, 8'hF0);
        $display("test write done");
    endtask
    task automatic t_protect();
        logic [7:0] r;
        sess(8'h06, 8'h00, 1, r);
        sess(8'h01, 8'h0C, 2, r);
        wait_busy(1'b1, 20);
        chk(fl(), 8'h06);
        wait_busy(1'b0, WC);
        sess(8'h05, 8'h00, 2, r);
        chk(r, 8'hFC);
        sess(8'h06, 8'h00, 1, r);
        wr(8'h3C);
        wait_busy(1'b1, 40);
        chk(fl(), 8'h03);
        sess(8'h01, 8'h00, 2, r);
        wait_busy(1'b1, 20);
        wait_busy(1'b0, WC);
        sess(8'h05, 8'h00, 2, r);
        chk(r, 8'hF0);
        $display("test protect done");
    endtask
    task automatic t_read();
        logic [7:0] r;
        u_host.set_mode3(1'b1);
        u_host.cs_lo();
        u_host.xb(8'h03, -1, r);
        u_host.xb(8'h10, -1, r);
        u_host.xb(8'h00, 4, r);
        u_host.cs_hi();
        chk(r, 8'hA5);
        chk(fl(), 8'h01);
        $display("test read done");
    endtask
    initial begin
        #200us;
        num_errors++;
        final_report();
    end
    initial begin
        rst_n = 1'b0;
        repeat (16) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge clk);
        #1 chk(fl(), 8'h01);
        $display("test reset done");
        t_latch();
        t_write();
        t_protect();
        t_read();
        final_report();
    end
endmodule
